/* rtl/nvcfg_access.sv */
// Summary of operation
// - Power-up loads write registers from memory
// - Address-select slot holds layout version
// - Address-select register skipped during load
// - Load only when stored version matches
// - Built-in version readable in ident register
// - Reset bit resets link logic, self-clears
// - Read trigger reads addressed byte, self-clears
// - Write trigger stores write byte, self-clears
// - Address register feeds next operation
// - Write byte register feeds next write
`timescale 1ns/1ps
module nvcfg_access (
  // System clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial memory link
  input wire logic link_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic scl_o,
  output logic scl_oe,
  // Write register bank load port
  output nvcfg_pkg::nvcfg_load_t bank_load
);
  import nvcfg_pkg::*;

  // Bus side state
  nvcfg_hstate_t state_r, state_nxt;
  nvcfg_kind_t kind_r, kind_nxt;
  nvcfg_aphase_t ap_r, ap_nxt;
  nvcfg_req_t req_r, req_nxt;
  nvcfg_load_t load_r, load_nxt;
  logic abort_r, abort_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic irst_tgl_r, irst_tgl_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic [7:0] rbyte_r, rbyte_nxt;
  logic nack_r, nack_nxt;
  logic boot_done_r, boot_done_nxt;
  logic boot_ok_r, boot_ok_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic ack_m1, ack_s;
  logic done;

  // Link side state
  nvcfg_lstate_t lst_r, lst_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] div_r, div_nxt;
  logic [1:0] bsel_r, bsel_nxt;
  logic [3:0] bitn_r, bitn_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] ldat_r, ldat_nxt;
  logic lnack_r, lnack_nxt;
  logic scl_oe_r, scl_oe_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic ack_tgl_r, ack_tgl_nxt;
  logic lrst_m1, lrst_n;
  logic req_m1, req_s;
  logic ir_m1, ir_s, ir_d;
  logic sda_m1, sda_s;
  logic tick, rx, ir_edge;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign bank_load = load_r;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

  // Completion seen once the returned toggle matches ours
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_m1 <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      ack_m1 <= ack_tgl_r;
      ack_s <= ack_m1;
    end
  end
  assign done = (state_r == H_WAIT) && (ack_s == req_tgl_r);

  // Bus decode, commands and power-up sequencing
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    req_nxt = req_r;
    abort_nxt = abort_r;
    req_tgl_nxt = req_tgl_r;
    irst_tgl_nxt = irst_tgl_r;
    addr_nxt = addr_r;
    wbyte_nxt = wbyte_r;
    rbyte_nxt = rbyte_r;
    nack_nxt = nack_r;
    boot_done_nxt = boot_done_r;
    boot_ok_nxt = boot_ok_r;
    load_nxt = '0;
    load_nxt.addr = load_r.addr;
    ap_nxt.valid = hsel && htrans[1] && hready;
    ap_nxt.write = hwrite;
    ap_nxt.mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
    ap_nxt.idx = haddr[9:2];
    hrdata_nxt = '0;
    // Read data is sampled in the address phase
    if (ap_nxt.valid && !hwrite && ap_nxt.mapped) begin
      if (haddr[9:2] == IDX_STATUS) begin
        hrdata_nxt[ST_PENDING] = (state_r == H_WAIT);
        hrdata_nxt[ST_BOOT_DONE] = boot_done_r;
        hrdata_nxt[ST_BOOT_LOADED] = boot_ok_r;
        hrdata_nxt[ST_NACK] = nack_r;
        hrdata_nxt[ST_RBYTE_LSB +: 8] = rbyte_r;
      end else if (haddr[9:2] == IDX_IDENT) begin
        hrdata_nxt[7:0] = LAYOUT_VERSION;
      end
    end
    // Finished transfer
    if (done) begin
      state_nxt = H_IDLE;
      nack_nxt = lnack_r;
      if (abort_r) begin
        abort_nxt = 1'b0;
        boot_done_nxt = 1'b1;
      end else begin
        unique case (kind_r)
          K_VER: begin
            if (!lnack_r && ldat_r == LAYOUT_VERSION) begin
              kind_nxt = K_LOAD;
              req_nxt = '{wr: 1'b0, addr: LOAD_FIRST, data: BYTE_RST};
              req_tgl_nxt = ~req_tgl_r;
              state_nxt = H_WAIT;
            end else begin
              boot_done_nxt = 1'b1;
            end
          end
          K_LOAD: begin
            load_nxt = '{valid: !lnack_r, addr: req_r.addr, data: ldat_r};
            if (!lnack_r && req_r.addr == IDX_WBYTE) begin
              wbyte_nxt = ldat_r;
            end
            if (lnack_r || req_r.addr == LOAD_LAST) begin
              boot_done_nxt = 1'b1;
              boot_ok_nxt = !lnack_r;
            end else begin
              req_nxt.addr = (req_r.addr == VERSION_SLOT - 8'h02) ?
                             VERSION_SLOT + 8'h01 : req_r.addr + 8'h01;
              req_tgl_nxt = ~req_tgl_r;
              state_nxt = H_WAIT;
            end
          end
          K_HOST: begin
            if (!req_r.wr && !lnack_r) begin
              rbyte_nxt = ldat_r;
            end
          end
        endcase
      end
    end
    // Data phase writes
    if (ap_r.valid && ap_r.write && ap_r.mapped) begin
      if (ap_r.idx == IDX_ADDR) begin
        addr_nxt = hwdata[7:0];
      end else if (ap_r.idx == IDX_WBYTE) begin
        wbyte_nxt = hwdata[7:0];
      end else if (ap_r.idx == IDX_CMD) begin
        if (hwdata[CMD_RST]) begin
          irst_tgl_nxt = ~irst_tgl_r;
          abort_nxt = (state_nxt == H_WAIT);
          kind_nxt = K_HOST;
        end else if (state_nxt == H_IDLE && (hwdata[CMD_RD] || hwdata[CMD_WR])) begin
          req_nxt = '{wr: !hwdata[CMD_RD], addr: addr_r, data: wbyte_r};
          req_tgl_nxt = ~req_tgl_r;
          kind_nxt = K_HOST;
          state_nxt = H_WAIT;
          nack_nxt = 1'b0;
        end
      end
    end
  end

  // Bus side registers; triggers are never stored, so they read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // first read fetches the version slot
      state_r <= H_WAIT;
      kind_r <= K_VER;
      req_r <= '{wr: 1'b0, addr: VERSION_SLOT, data: BYTE_RST};
      req_tgl_r <= 1'b1;
      abort_r <= 1'b0;
      irst_tgl_r <= 1'b0;
      addr_r <= BYTE_RST;
      wbyte_r <= BYTE_RST;
      rbyte_r <= BYTE_RST;
      nack_r <= 1'b0;
      boot_done_r <= 1'b0;
      boot_ok_r <= 1'b0;
      load_r <= '0;
      ap_r <= '0;
      hrdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      req_r <= req_nxt;
      req_tgl_r <= req_tgl_nxt;
      abort_r <= abort_nxt;
      irst_tgl_r <= irst_tgl_nxt;
      addr_r <= addr_nxt;
      wbyte_r <= wbyte_nxt;
      rbyte_r <= rbyte_nxt;
      nack_r <= nack_nxt;
      boot_done_r <= boot_done_nxt;
      boot_ok_r <= boot_ok_nxt;
      load_r <= load_nxt;
      ap_r <= ap_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Link reset released in step with the link clock
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      lrst_m1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_m1 <= 1'b1;
      lrst_n <= lrst_m1;
    end
  end

  // Toggles and the data pin cross on two flops; payload is static meanwhile
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_m1 <= 1'b0;
      req_s <= 1'b0;
      ir_m1 <= 1'b0;
      ir_s <= 1'b0;
      ir_d <= 1'b0;
      sda_m1 <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      req_m1 <= req_tgl_r;
      req_s <= req_m1;
      ir_m1 <= irst_tgl_r;
      ir_s <= ir_m1;
      ir_d <= ir_s;
      sda_m1 <= sda_i;
      sda_s <= sda_m1;
    end
  end
  assign ir_edge = ir_s ^ ir_d;
  assign tick = (div_r == 4'h0);
  assign rx = (bsel_r == 2'd3);

  // Byte engine: write is dev, addr, data; read adds restart, dev, byte
  always_comb begin
    lst_nxt = lst_r;
    q_nxt = q_r;
    div_nxt = tick ? QDIV_RELOAD : div_r - 4'h1;
    bsel_nxt = bsel_r;
    bitn_nxt = bitn_r;
    sh_nxt = sh_r;
    ldat_nxt = ldat_r;
    lnack_nxt = lnack_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    ack_tgl_nxt = ack_tgl_r;
    if (ir_edge) begin
      // drop the bus, answer any request
      lst_nxt = L_IDLE;
      scl_oe_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
      ack_tgl_nxt = req_s;
    end else begin
      unique case (lst_r)
        L_IDLE: begin
          if (req_s != ack_tgl_r) begin
            lst_nxt = L_START;
            q_nxt = 2'd0;
            bsel_nxt = 2'd0;
            lnack_nxt = 1'b0;
          end
        end
        L_START: if (tick) begin
          q_nxt = q_r + 2'd1;
          unique case (q_r)
            2'd0: sda_oe_nxt = 1'b0;
            2'd1: scl_oe_nxt = 1'b0;
            2'd2: sda_oe_nxt = 1'b1;
            default: begin
              scl_oe_nxt = 1'b1;
              sh_nxt = (bsel_r == 2'd0) ? {NV_DEV_ADDR, 1'b0} : {NV_DEV_ADDR, 1'b1};
              bitn_nxt = 4'h0;
              lst_nxt = L_BIT;
            end
          endcase
        end
        L_BIT: if (tick) begin
          q_nxt = q_r + 2'd1;
          unique case (q_r)
            2'd0: sda_oe_nxt = (bitn_r != BITN_ACK) && !rx && !sh_r[7];
            2'd1: scl_oe_nxt = 1'b0;
            2'd2: begin
              if (bitn_r != BITN_ACK) begin
                sh_nxt = {sh_r[6:0], sda_s};
              end else if (!rx && sda_s) begin
                lnack_nxt = 1'b1;
              end
            end
            default: begin
              scl_oe_nxt = 1'b1;
              bitn_nxt = bitn_r + 4'h1;
              if (bitn_r == BITN_ACK) begin
                if (lnack_r || rx || (bsel_r == 2'd2 && req_r.wr)) begin
                  ldat_nxt = rx ? sh_r : ldat_r;
                  lst_nxt = L_STOP;
                end else if (bsel_r == 2'd1 && !req_r.wr) begin
                  bsel_nxt = 2'd2;
                  lst_nxt = L_START;
                end else begin
                  bsel_nxt = bsel_r + 2'd1;
                  sh_nxt = (bsel_r == 2'd0) ? req_r.addr : req_r.data;
                  bitn_nxt = 4'h0;
                end
              end
            end
          endcase
        end
        L_STOP: if (tick) begin
          q_nxt = q_r + 2'd1;
          unique case (q_r)
            2'd0: sda_oe_nxt = 1'b1;
            2'd1: scl_oe_nxt = 1'b0;
            2'd2: sda_oe_nxt = 1'b0;
            default: begin
              lst_nxt = L_IDLE;
              ack_tgl_nxt = req_s;
            end
          endcase
        end
      endcase
    end
  end

  // Link side registers
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lst_r <= L_IDLE;
      q_r <= 2'd0;
      div_r <= QDIV_RELOAD;
      bsel_r <= 2'd0;
      bitn_r <= 4'h0;
      sh_r <= BYTE_RST;
      ldat_r <= BYTE_RST;
      lnack_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else begin
      lst_r <= lst_nxt;
      q_r <= q_nxt;
      div_r <= div_nxt;
      bsel_r <= bsel_nxt;
      bitn_r <= bitn_nxt;
      sh_r <= sh_nxt;
      ldat_r <= ldat_nxt;
      lnack_r <= lnack_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      ack_tgl_r <= ack_tgl_nxt;
    end
  end
endmodule // nvcfg_access

/* rtl/nvcfg_pkg.sv */
package nvcfg_pkg;
  // Link timing: one bit is four quarter phases
  localparam int unsigned LINK_PERIOD_PS = 48000;
  localparam int unsigned QUARTER_PS = 625000;
  localparam int unsigned QUARTER_CYC = (QUARTER_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [3:0] QDIV_RELOAD = 4'(QUARTER_CYC - 1);
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CMD = 8'h5C;
  localparam logic [7:0] IDX_ADDR = 8'h5D;
  localparam logic [7:0] IDX_WBYTE = 8'h5E;
  localparam logic [7:0] IDX_STATUS = 8'h60;
  localparam logic [7:0] IDX_IDENT = 8'h61;
  // Command bits
  localparam int CMD_RST = 0;
  localparam int CMD_RD = 1;
  localparam int CMD_WR = 2;
  // Status fields
  localparam int ST_PENDING = 0;
  localparam int ST_BOOT_DONE = 1;
  localparam int ST_BOOT_LOADED = 2;
  localparam int ST_NACK = 3;
  localparam int ST_RBYTE_LSB = 8;
  // Built-in layout version and memory slave address
  localparam logic [7:0] LAYOUT_VERSION = 8'h01;
  localparam logic [6:0] NV_DEV_ADDR = 7'h50;
  // Power-up load range; the version slot is skipped
  localparam logic [7:0] LOAD_FIRST = 8'h20;
  localparam logic [7:0] LOAD_LAST = 8'h7D;
  localparam logic [7:0] VERSION_SLOT = IDX_ADDR;
  // Reset value and acknowledge bit number
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] BITN_ACK = 4'h8;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } nvcfg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } nvcfg_load_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [7:0] idx;
  } nvcfg_aphase_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } nvcfg_hstate_t;

  typedef enum logic [2:0] {
    K_VER = 3'b001,
    K_LOAD = 3'b010,
    K_HOST = 3'b100
  } nvcfg_kind_t;

  typedef enum logic [3:0] {
    L_IDLE = 4'b0001,
    L_START = 4'b0010,
    L_BIT = 4'b0100,
    L_STOP = 4'b1000
  } nvcfg_lstate_t;
endpackage

/* testbench/nvcfg_access_bench.sv */
`timescale 1ns/1ps
module nvcfg_access_bench;
  import nvcfg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, link_clk, refuse;
  logic hreadyout, hresp, sda_o, sda_oe, scl_o, scl_oe, sda_pull;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [7:0] ra [2] = '{8'h44, 8'h33};
  logic [7:0] re [2] = '{8'h78, 8'hA5};
  wire scl, sda;
  nvcfg_load_t bank_load;
  nvcfg_load_t lq [$];
  int fail_count, n_tests, k, n;
  // Open-drain wires with pull-ups
  assign scl = !scl_oe;
  assign sda = !(sda_oe || sda_pull);
  nvcfg_access dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
    .bank_load(bank_load));
  nvcfg_mem_model mem_u (.scl(scl), .sda(sda), .refuse(refuse), .sda_pull(sda_pull));
  // Clocks; link phase offset keeps the domains unrelated
  always #25 hclk = ~hclk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // Record every bank load pulse
  always @(posedge hclk) begin
    if (bank_load.valid === 1'b1)
      lq.push_back(bank_load);
  end
  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    if (i == 50) begin
      fail_count++;
      finish_test();
    end
  endtask
  // One single AHB transfer; read data taken at the closing edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic poll();
    int i;
    for (i = 0; i < 20000; i++) begin
      bus(1'b0, 32'h180, 32'h0, v);
      if (v[0] === 1'b0)
        break;
    end
    if (i == 20000) begin
      fail_count++;
      finish_test();
    end
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    refuse = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    poll();
    chk(v & 32'h7, 32'h2);
    chk(32'(lq.size()), 32'h0);
    bus(1'b0, 32'h184, 32'h0, v);
    chk(v, {24'h0, LAYOUT_VERSION});
    bus(1'b0, 32'h170, 32'h0, v);
    chk(v, 32'h0);
    bus(1'b0, 32'h3FC, 32'h0, v);
    chk(v, 32'h0);
    $display("Test boot_disabled done");
    bus(1'b1, 32'h174, 32'h33, v);
    bus(1'b1, 32'h178, 32'hA5, v);
    bus(1'b1, 32'h170, 32'h4, v);
    bus(1'b0, 32'h180, 32'h0, v);
    chk(v & 32'h1, 32'h1);
    poll();
    chk(32'(mem_u.mem[8'h33]), 32'hA5);
    chk(v & 32'h8, 32'h0);
    $display("Test host_write done");
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 32'h174, 32'(ra[i]), v);
      bus(1'b1, 32'h170, 32'h2, v);
      bus(1'b1, 32'h170, 32'h4, v);
      bus(1'b0, 32'h180, 32'h0, v);
      chk(v & 32'h1, 32'h1);
      poll();
      chk(32'(v[15:8]), 32'(re[i]));
    end
    chk(32'(mem_u.mem[8'h44]), 32'h78);
    $display("Test host_read done");
    refuse <= 1'b1;
    bus(1'b1, 32'h170, 32'h2, v);
    poll();
    chk(v & 32'hFF08, 32'hA508);
    refuse <= 1'b0;
    $display("Test refused done");
    bus(1'b1, 32'h174, {24'h0, VERSION_SLOT}, v);
    bus(1'b1, 32'h178, {24'h0, LAYOUT_VERSION}, v);
    bus(1'b1, 32'h170, 32'h4, v);
    poll();
    lq.delete();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (k = 0; k < 20000 && lq.size() < 2; k++)
      @(posedge hclk);
    if (lq.size() < 2) begin
      fail_count++;
      finish_test();
    end
    chk({16'h0, lq[0].addr, lq[0].data}, {16'h0, LOAD_FIRST, 8'h1C});
    chk({16'h0, lq[1].addr, lq[1].data}, 32'h211D);
    bus(1'b1, 32'h170, 32'h1, v);
    poll();
    chk(v & 32'h7, 32'h2);
    n = lq.size();
    repeat (3000) @(posedge hclk);
    chk(32'(lq.size()), 32'(n));
    chk({28'h0, scl_o, sda_o, scl_oe, sda_oe}, 32'h0);
    $display("Test boot_load done");
    finish_test();
  end
endmodule // nvcfg_access_bench
bind nvcfg_access nvcfg_access_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk), .scl_oe(scl_oe),
  .bank_load(bank_load));

/* testbench/nvcfg_access_checker.sv */
`timescale 1ns/1ps
module nvcfg_access_checker (
  // System side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Link side
  input wire logic link_clk,
  input wire logic scl_oe,
  input wire nvcfg_pkg::nvcfg_load_t bank_load
);
  import nvcfg_pkg::*;
  logic rd;
  // Read taken in this address phase
  assign rd = hsel && htrans[1] && hready && !hwrite;
  property p_okay;
    @(posedge hclk) disable iff (!hresetn) hreadyout && !hresp;
  endproperty
  property p_wo_zero;
    @(posedge hclk) disable iff (!hresetn)
      rd && haddr != 32'h180 && haddr != 32'h184 |=> hrdata == 32'h0;
  endproperty
  property p_ident;
    @(posedge hclk) disable iff (!hresetn)
      rd && haddr == 32'h184 |=> hrdata == {24'h0, LAYOUT_VERSION};
  endproperty
  property p_rd_stand;
    @(posedge hclk) disable iff (!hresetn) !rd |=> hrdata == 32'h0;
  endproperty
  property p_status_hi;
    @(posedge hclk) disable iff (!hresetn)
      rd && haddr == 32'h180 |=> hrdata[31:16] == 16'h0 && hrdata[7:4] == 4'h0;
  endproperty
  property p_load_pulse;
    @(posedge hclk) disable iff (!hresetn) bank_load.valid |=> !bank_load.valid [*8];
  endproperty
  property p_load_skip;
    @(posedge hclk) disable iff (!hresetn) bank_load.valid |->
      bank_load.addr >= LOAD_FIRST && bank_load.addr <= LOAD_LAST &&
      bank_load.addr != IDX_CMD && bank_load.addr != VERSION_SLOT;
  endproperty
  property p_scl_high;
    @(posedge link_clk) disable iff (!hresetn) $fell(scl_oe) |-> !scl_oe [*8];
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or okay");
  a_wo_zero: assert property (p_wo_zero) else $error("unreadable place not zero");
  a_ident: assert property (p_ident) else $error("ident value wrong");
  a_rd_stand: assert property (p_rd_stand) else $error("read data outside phase");
  a_status_hi: assert property (p_status_hi) else $error("status spare bits set");
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
  a_load_skip: assert property (p_load_skip) else $error("load offset illegal");
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  c_load: cover property (@(posedge hclk) bank_load.valid);
  c_status: cover property (@(posedge hclk) rd && haddr == 32'h180);
  c_scl: cover property (@(posedge link_clk) $fell(scl_oe));
endmodule // nvcfg_access_checker

/* testbench/nvcfg_mem_model.sv */
`timescale 1ns/1ps
module nvcfg_mem_model (
  // Resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // Bench command: refuse every byte
  input wire logic refuse,
  // High pulls the data wire low
  output logic sda_pull
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic act, rdm, ok;
  int cnt, nb;
  // Distinct contents per offset
  // version slot disabled
  initial begin
    sda_pull = 1'b0;
    act = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h3C;
    mem[8'h5D] = 8'h00;
  end
  // Start or stop: data moves while the clock is high
  always @(sda) begin
    if (scl === 1'b1) begin
      act = !sda;
      cnt = 0;
      nb = 0;
      ok = !refuse;
      sda_pull = 1'b0;
    end
  end
  // Shift in on rising clock; the ninth clock settles the byte
  always @(posedge scl) begin
    if (act && cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt++;
    end else if (act) begin
      if (nb == 0) begin
        rdm = sh[0];
        ok = ok && (sh[7:1] == 7'h50);
      end else if (rdm) begin
        ok = ok && !sda;
        ptr++;
      end else if (nb == 1)
        ptr = sh;
      else if (ok) begin
        mem[ptr] = sh;
        ptr++;
      end
      cnt = 0;
      nb++;
    end
  end
  // Drive acknowledge or read bits only while the clock is low
  always @(negedge scl) begin
    if (act && cnt == 8)
      sda_pull = ok && !(rdm && nb > 0);
    else if (act && rdm && nb > 0 && ok)
      sda_pull = !mem[ptr][7 - cnt];
    else
      sda_pull = 1'b0;
  end
endmodule // nvcfg_mem_model
